// >>> logic/pcl_defines.svh
`ifndef PCL_DEFINES_SVH
`define PCL_DEFINES_SVH

// oscillator page, index within page (addr[3] = 0)
`define PCL_OSC_CTRL 3'h0
`define PCL_OSC_STATUS 3'h1
`define PCL_OSC_XCTRL 3'h2
`define PCL_OSC_FAIL 3'h3
`define PCL_OSC_RCCAL 3'h4
`define PCL_OSC_PLL 3'h5
`define PCL_OSC_REFSEL 3'h6
// calibration loop page (addr[3] = 1)
`define PCL_CAL_CTRL 3'h0
`define PCL_CAL_FINE 3'h2
`define PCL_CAL_COARSE 3'h3
`define PCL_CAL_CMPLO 3'h5
`define PCL_CAL_CMPHI 3'h6

// failure register bit positions
`define PCL_FAIL_PLLFLAG 3
`define PCL_FAIL_PLLEN 2
`define PCL_FAIL_XFLAG 1
`define PCL_FAIL_XEN 0

// field positions in pll control and reference select
`define PCL_PLL_SRC_HI 7
`define PCL_PLL_SRC_LO 6
`define PCL_PLL_HALF 5
`define PCL_REF_FAST_HI 2
`define PCL_REF_FAST_LO 1
`define PCL_REF_SLOW 0

// reset values and count limits
`define PCL_RST_OSCEN 5'h01
`define PCL_RST_COMPARE 16'h7a12
`define PCL_FINE_MAX 7'h7f
`define PCL_FINE_MIN 7'h00
`define PCL_COUNT_MAX 16'hffff

// last divider count: 32 reference edges of 32.768 kHz per 1.024 kHz period
`define PCL_REF_DIV 5'h1f
// failure interrupt vector word offset
`define PCL_NMI_VECTOR 8'h00

`endif

// >>> logic/pcl_pkg.sv
package pcl_pkg;

    typedef enum logic [1:0] {
        PCL_SRC_OSC2M = 2'b00,
        PCL_SRC_RSVD = 2'b01,
        PCL_SRC_OSC32M = 2'b10,
        PCL_SRC_EXT = 2'b11
    } pcl_pll_src_t;

    typedef enum logic [1:0] {
        PCL_REF_INT32K = 2'b00,
        PCL_REF_XTAL32K = 2'b01,
        PCL_REF_USB_FRAME_START_REF = 2'b10,
        PCL_REF_RSVD = 2'b11
    } pcl_cal_ref_t;

    typedef enum logic [1:0] {
        PCL_LOOP_IDLE = 2'b00,
        PCL_LOOP_ARM = 2'b01,
        PCL_LOOP_RUN = 2'b10,
        PCL_LOOP_STOP = 2'b11
    } pcl_loop_st_t;

endpackage

// >>> logic/pcl_clock_ctrl.sv
// Functional notes
// - PLL source: 00 2M, 10 32M, 11 external
// - half-output bit halves PLL output
// - five-bit multiplier, one to thirty-one; code also stores zero, its reset value
// - fast loop reference: int32k, crystal, SOF
// - slow loop reference: int32k or crystal
// - enable bit starts and stops auto calibration
// - enable reads one until loop stopped
// - calibration value: 7 fine, 6 coarse bits
// - idle loop: software writes set calibration
// - reset loads factory calibration value
// - calibration writes ignored while loop runs
// - loop adjusts only the fine part
// - 16-bit compare split low and high
// - compare resets to 0x7a12
// - both failures share vector offset zero
// - PLL lock loss sets flag, NMI, W1C
// - oscillator failure sets flag, NMI, W1C
//
// Our own choice: the strobed register port.
`include "pcl_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module pcl_clock_ctrl
    import pcl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    input wire logic [4:0] oscReadyIn,
    input wire logic pllLockIn,
    input wire logic extOscFailIn,
    input wire logic oscTickIn,
    input wire logic refInt32kIn,
    input wire logic refXtal32kIn,
    input wire logic usbFrameStartIn,
    input wire logic [12:0] factoryCalIn,
    input wire logic [7:0] factoryRcCalIn,
    output logic [4:0] oscEnable,
    output logic [7:0] extOscConfig,
    output logic [7:0] slowRcCal,
    output logic [1:0] pllInputSelect,
    output logic pllHalfOutput,
    output logic [4:0] pllMultiplier,
    output logic [1:0] fastRcCalReference,
    output logic slowRcCalReference,
    output logic [12:0] calValue,
    output logic nmiReq,
    output logic [7:0] nmiVector
);

    // async inputs: ready[4:0], lock, fail, tick, int32k, xtal, sof
    localparam int NSYNC = 11;
    logic [NSYNC-1:0] syncA_ff, syncB_ff, asyncIn;
    logic lockSy, failSy, tickSy, tickDly_ff, refDly_ff, refSel;
    logic [4:0] readySy, oscEn_ff, pllMul_ff, refDiv_ff;
    logic [7:0] xCtrl_ff, rcCal_ff, rdData_ff, nxt_rdData;
    logic [1:0] pll_input_select_ff, fastRef_ff;
    logic pllHalf_ff, slowRef_ff, loopEnReq_ff;
    logic pllFlag_ff, pllFdEn_ff, xFlag_ff, xFdEn_ff;
    logic lockDly_ff, failDly_ff, nmi_ff;
    pcl_loop_st_t loopSt_ff, nxt_loopSt;
    logic [6:0] calFine_ff;
    logic [5:0] calCoarse_ff;
    logic [15:0] compare_ff, oscCount_ff;
    logic refEdge, refEvt, lockLoss, failRise, oscWr, calWr;

    default disable iff (rst);

    assign asyncIn = {usbFrameStartIn, refXtal32kIn, refInt32kIn,
        oscTickIn, extOscFailIn, pllLockIn, oscReadyIn};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            syncA_ff <= '0;
            syncB_ff <= '0;
        end else begin
            syncA_ff <= asyncIn;
            syncB_ff <= syncA_ff;
        end
    end

    assign readySy = syncB_ff[4:0];
    assign lockSy = syncB_ff[5];
    assign failSy = syncB_ff[6];
    assign tickSy = syncB_ff[7];

    always_comb begin
        case (pcl_cal_ref_t'(fastRef_ff))
            PCL_REF_INT32K: refSel = syncB_ff[8];
            PCL_REF_XTAL32K: refSel = syncB_ff[9];
            PCL_REF_USB_FRAME_START_REF: refSel = syncB_ff[10];
            default: refSel = 1'b0;
        endcase
    end

    assign oscWr = regWrEn && !regAddr[3];
    assign calWr = regWrEn && regAddr[3];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            oscEn_ff <= `PCL_RST_OSCEN;
            xCtrl_ff <= 8'h00;
            pllHalf_ff <= 1'b0;
            pllMul_ff <= 5'h00;
        end else if (oscWr) begin
            case (regAddr[2:0])
                `PCL_OSC_CTRL: oscEn_ff <= regWrData[4:0];
                `PCL_OSC_XCTRL: xCtrl_ff <= regWrData;
                `PCL_OSC_PLL: begin
                    pllHalf_ff <= regWrData[`PCL_PLL_HALF];
                    pllMul_ff <= regWrData[4:0];
                end
                default: begin
                end
            endcase
        end
    end

    // a reserved source code is dropped so the PLL never sees it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pll_input_select_ff <= PCL_SRC_OSC2M;
        end else if (oscWr && regAddr[2:0] == `PCL_OSC_PLL
            && regWrData[7:6] != PCL_SRC_RSVD) begin
            pll_input_select_ff <= regWrData[`PCL_PLL_SRC_HI:`PCL_PLL_SRC_LO];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fastRef_ff <= PCL_REF_INT32K;
            slowRef_ff <= 1'b0;
        end else if (oscWr && regAddr[2:0] == `PCL_OSC_REFSEL) begin
            slowRef_ff <= regWrData[`PCL_REF_SLOW];
            if (regWrData[2:1] != PCL_REF_RSVD) begin
                fastRef_ff <=
                    regWrData[`PCL_REF_FAST_HI:`PCL_REF_FAST_LO];
            end
        end
    end

    // factory value is a strap level taken on the clocked reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rcCal_ff <= factoryRcCalIn;
        end else if (oscWr && regAddr[2:0] == `PCL_OSC_RCCAL) begin
            rcCal_ff <= regWrData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lockDly_ff <= 1'b0;
            failDly_ff <= 1'b0;
        end else begin
            lockDly_ff <= lockSy;
            failDly_ff <= failSy;
        end
    end

    assign lockLoss = lockDly_ff && !lockSy;
    assign failRise = failSy && !failDly_ff;

    // detection enables stick once set; only reset clears them
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pllFdEn_ff <= 1'b0;
            xFdEn_ff <= 1'b0;
        end else if (oscWr && regAddr[2:0] == `PCL_OSC_FAIL) begin
            pllFdEn_ff <= pllFdEn_ff | regWrData[`PCL_FAIL_PLLEN];
            xFdEn_ff <= xFdEn_ff | regWrData[`PCL_FAIL_XEN];
        end
    end

    // a fault in the clearing cycle wins over the write-one clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pllFlag_ff <= 1'b0;
        end else if (pllFdEn_ff && lockLoss) begin
            pllFlag_ff <= 1'b1;
        end else if (oscWr && regAddr[2:0] == `PCL_OSC_FAIL
            && regWrData[`PCL_FAIL_PLLFLAG]) begin
            pllFlag_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            xFlag_ff <= 1'b0;
        end else if (xFdEn_ff && failRise) begin
            xFlag_ff <= 1'b1;
        end else if (oscWr && regAddr[2:0] == `PCL_OSC_FAIL
            && regWrData[`PCL_FAIL_XFLAG]) begin
            xFlag_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            nmi_ff <= 1'b0;
        end else begin
            nmi_ff <= (pllFlag_ff && pllFdEn_ff)
                || (xFlag_ff && xFdEn_ff);
        end
    end

    // reference period: 32 kHz sources divided down to 1.024 kHz
    always_ff @(posedge core_clk) begin
        if (rst) begin
            refDly_ff <= 1'b0;
            tickDly_ff <= 1'b0;
            refDiv_ff <= 5'h00;
        end else begin
            refDly_ff <= refSel;
            tickDly_ff <= tickSy;
            if (refEdge) begin
                refDiv_ff <= (refDiv_ff == `PCL_REF_DIV) ? 5'h00
                    : refDiv_ff + 5'h01;
            end
        end
    end

    assign refEdge = refSel && !refDly_ff;
    assign refEvt = refEdge && (fastRef_ff == PCL_REF_USB_FRAME_START_REF
        || refDiv_ff == `PCL_REF_DIV);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            loopEnReq_ff <= 1'b0;
        end else if (calWr && regAddr[2:0] == `PCL_CAL_CTRL) begin
            loopEnReq_ff <= regWrData[0];
        end
    end

    // stopping waits for the period end, so a stopped reference hangs it
    always_comb begin
        nxt_loopSt = loopSt_ff;
        case (loopSt_ff)
            PCL_LOOP_IDLE: if (loopEnReq_ff) nxt_loopSt = PCL_LOOP_ARM;
            PCL_LOOP_ARM: begin
                if (!loopEnReq_ff) nxt_loopSt = PCL_LOOP_IDLE;
                else if (refEvt) nxt_loopSt = PCL_LOOP_RUN;
            end
            PCL_LOOP_RUN: if (!loopEnReq_ff) nxt_loopSt = PCL_LOOP_STOP;
            PCL_LOOP_STOP: begin
                if (loopEnReq_ff) nxt_loopSt = PCL_LOOP_RUN;
                else if (refEvt) nxt_loopSt = PCL_LOOP_IDLE;
            end
            default: nxt_loopSt = PCL_LOOP_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            loopSt_ff <= PCL_LOOP_IDLE;
        end else begin
            loopSt_ff <= nxt_loopSt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || refEvt) begin
            oscCount_ff <= 16'h0000;
        end else if (tickSy && !tickDly_ff
            && oscCount_ff != `PCL_COUNT_MAX) begin
            oscCount_ff <= oscCount_ff + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            calFine_ff <= factoryCalIn[6:0];
        end else if (loopSt_ff == PCL_LOOP_RUN && refEvt) begin
            if (oscCount_ff < compare_ff && calFine_ff != `PCL_FINE_MAX) begin
                calFine_ff <= calFine_ff + 7'h01;
            end else if (oscCount_ff > compare_ff
                && calFine_ff != `PCL_FINE_MIN) begin
                calFine_ff <= calFine_ff - 7'h01;
            end
        end else if (loopSt_ff == PCL_LOOP_IDLE && calWr
            && regAddr[2:0] == `PCL_CAL_FINE) begin
            calFine_ff <= regWrData[6:0];
        end
    end

    // coarse part is never touched by the loop
    always_ff @(posedge core_clk) begin
        if (rst) begin
            calCoarse_ff <= factoryCalIn[12:7];
        end else if (loopSt_ff == PCL_LOOP_IDLE && calWr
            && regAddr[2:0] == `PCL_CAL_COARSE) begin
            calCoarse_ff <= regWrData[5:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            compare_ff <= `PCL_RST_COMPARE;
        end else if (calWr && regAddr[2:0] == `PCL_CAL_CMPLO) begin
            compare_ff[7:0] <= regWrData;
        end else if (calWr && regAddr[2:0] == `PCL_CAL_CMPHI) begin
            compare_ff[15:8] <= regWrData;
        end
    end

    always_comb begin
        nxt_rdData = 8'h00;
        if (!regAddr[3]) begin
            case (regAddr[2:0])
                `PCL_OSC_CTRL: nxt_rdData = {3'h0, oscEn_ff};
                `PCL_OSC_STATUS: nxt_rdData = {3'h0, readySy};
                `PCL_OSC_XCTRL: nxt_rdData = xCtrl_ff;
                `PCL_OSC_FAIL: nxt_rdData = {4'h0, pllFlag_ff, pllFdEn_ff,
                    xFlag_ff, xFdEn_ff};
                `PCL_OSC_RCCAL: nxt_rdData = rcCal_ff;
                `PCL_OSC_PLL: nxt_rdData = {pll_input_select_ff, pllHalf_ff, pllMul_ff};
                `PCL_OSC_REFSEL: nxt_rdData = {5'h00, fastRef_ff, slowRef_ff};
                default: nxt_rdData = 8'h00;
            endcase
        end else begin
            case (regAddr[2:0])
                `PCL_CAL_CTRL: nxt_rdData = {7'h00,
                    loopSt_ff != PCL_LOOP_IDLE};
                `PCL_CAL_FINE: nxt_rdData = {1'b0, calFine_ff};
                `PCL_CAL_COARSE: nxt_rdData = {2'h0, calCoarse_ff};
                `PCL_CAL_CMPLO: nxt_rdData = compare_ff[7:0];
                `PCL_CAL_CMPHI: nxt_rdData = compare_ff[15:8];
                default: nxt_rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdData_ff <= 8'h00;
        end else begin
            rdData_ff <= regRdEn ? nxt_rdData : 8'h00;
        end
    end

    assign regRdData = rdData_ff;
    assign oscEnable = oscEn_ff;
    assign extOscConfig = xCtrl_ff;
    assign slowRcCal = rcCal_ff;
    assign pllInputSelect = pll_input_select_ff;
    assign pllHalfOutput = pllHalf_ff;
    assign pllMultiplier = pllMul_ff;
    assign fastRcCalReference = fastRef_ff;
    assign slowRcCalReference = slowRef_ff;
    assign calValue = {calCoarse_ff, calFine_ff};
    assign nmiReq = nmi_ff;
    assign nmiVector = `PCL_NMI_VECTOR;

    a_pll_src_rsvd: assert property (@(posedge core_clk)
        oscWr && regAddr[2:0] == `PCL_OSC_PLL && regWrData[7:6] == 2'b01
        |=> $stable(pll_input_select_ff)) else $error("reserved pll source stored");
    a_loop_start: assert property (@(posedge core_clk)
        loopSt_ff == PCL_LOOP_IDLE && loopEnReq_ff
        |=> loopSt_ff == PCL_LOOP_ARM) else $error("loop did not arm");
    a_stop_readback: assert property (@(posedge core_clk)
        loopSt_ff == PCL_LOOP_RUN && !loopEnReq_ff
        |=> loopSt_ff == PCL_LOOP_STOP ##1 (regRdData[0]
        || !$past(regRdEn && regAddr == 4'h8)))
        else $error("enable read zero before stop");
    a_manual_fine: assert property (@(posedge core_clk)
        loopSt_ff == PCL_LOOP_IDLE && calWr && regAddr[2:0] == `PCL_CAL_FINE
        |=> calFine_ff == $past(regWrData[6:0]))
        else $error("manual fine write lost");
    a_factory_load: assert property (@(posedge core_clk)
        $fell(rst) |-> calValue == factoryCalIn)
        else $error("factory value not loaded");
    a_coarse_held: assert property (@(posedge core_clk)
        loopSt_ff != PCL_LOOP_IDLE |=> $stable(calCoarse_ff))
        else $error("coarse changed while loop on");
    a_fine_step_up: assert property (@(posedge core_clk)
        loopSt_ff == PCL_LOOP_RUN && refEvt && oscCount_ff < compare_ff
        && calFine_ff != 7'h7f |=> calFine_ff == $past(calFine_ff) + 7'h01)
        else $error("fine did not step up");
    a_compare_reset: assert property (@(posedge core_clk)
        $fell(rst) |-> compare_ff == 16'h7a12)
        else $error("bad compare reset");
    a_pll_fault: assert property (@(posedge core_clk)
        pllFdEn_ff && lockLoss |=> pllFlag_ff ##1 nmiReq)
        else $error("pll fault not flagged");
    a_osc_fault: assert property (@(posedge core_clk)
        xFdEn_ff && failRise |=> xFlag_ff ##1 nmiReq)
        else $error("oscillator fault not flagged");

endmodule

`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb
    import pcl_pkg::*;
;
    // factory trim values are arbitrary test patterns
    localparam logic [12:0] FACTORY_CAL = 13'h0a5c;
    localparam logic [7:0] FACTORY_RC = 8'h96;

    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [7:0] regRdData;
    logic [4:0] oscReadyIn = 5'h15;
    logic pllLockIn = 1'b1;
    logic extOscFailIn = 1'b0;
    logic oscTickIn = 1'b0;
    logic refInt32kIn = 1'b0;
    logic refXtal32kIn = 1'b0;
    logic usbFrameStartIn = 1'b0;
    logic [4:0] oscEnable;
    logic [7:0] extOscConfig;
    logic [7:0] slowRcCal;
    logic [1:0] pllInputSelect;
    logic pllHalfOutput;
    logic [4:0] pllMultiplier;
    logic [1:0] fastRcCalReference;
    logic slowRcCalReference;
    logic [12:0] calValue;
    logic nmiReq;
    logic [7:0] nmiVector;
    logic refOn = 1'b1;
    logic [3:0] cyc = 4'h0;
    int bad_count = 0;
    int total_checks = 0;

    always #2 core_clk = ~core_clk;

    // tick runs 4x the reference pin, so one period counts 128 ticks
    always @(posedge core_clk) begin
        cyc <= cyc + 4'h1;
        oscTickIn <= cyc[1];
        refInt32kIn <= refOn & cyc[3];
    end

    pcl_clock_ctrl pcl_clock_ctrl_inst (
        .core_clk(core_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .oscReadyIn(oscReadyIn),
        .pllLockIn(pllLockIn), .extOscFailIn(extOscFailIn),
        .oscTickIn(oscTickIn), .refInt32kIn(refInt32kIn),
        .refXtal32kIn(refXtal32kIn), .usbFrameStartIn(usbFrameStartIn),
        .factoryCalIn(FACTORY_CAL), .factoryRcCalIn(FACTORY_RC),
        .oscEnable(oscEnable), .extOscConfig(extOscConfig),
        .slowRcCal(slowRcCal), .pllInputSelect(pllInputSelect),
        .pllHalfOutput(pllHalfOutput), .pllMultiplier(pllMultiplier),
        .fastRcCalReference(fastRcCalReference),
        .slowRcCalReference(slowRcCalReference), .calValue(calValue),
        .nmiReq(nmiReq), .nmiVector(nmiVector)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        #1 d = regRdData;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        check(d, e);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        summarize();
    end

    initial begin
        pcl_pll_src_t srcs [3];
        logic [7:0] v;
        logic [7:0] d;
        logic [7:0] d2;
        int n;
        srcs = '{PCL_SRC_OSC2M, PCL_SRC_OSC32M, PCL_SRC_EXT};
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        check(calValue, FACTORY_CAL);
        check(oscEnable, 5'h01);
        check(slowRcCal, FACTORY_RC);
        check(nmiVector, 8'h00);
        rdc(4'h0, 8'h01);
        rdc(4'h1, 8'h15);
        rdc(4'h3, 8'h00);
        rdc(4'h5, 8'h00);
        rdc(4'h6, 8'h00);
        rdc(4'h8, 8'h00);
        rdc(4'ha, {1'b0, FACTORY_CAL[6:0]});
        rdc(4'hb, {2'b00, FACTORY_CAL[12:7]});
        rdc(4'hd, 8'h12);
        rdc(4'he, 8'h7a);
        rdc(4'h7, 8'h00);
        rdc(4'hf, 8'h00);
        $display("test reset values done");

        for (int i = 0; i < 3; i++) begin
            v = {srcs[i], i[0], (i == 1) ? 5'h1f : 5'h01};
            wr(4'h5, v);
            check(pllInputSelect, srcs[i]);
            check(pllHalfOutput, i[0]);
            check(pllMultiplier, v[4:0]);
            rdc(4'h5, v);
        end
        // reserved source code keeps the previous source only
        wr(4'h5, 8'h6a);
        rdc(4'h5, 8'hea);
        $display("test pll control done");

        for (int f = 0; f < 3; f++) begin
            v = {5'h00, f[1:0], ~f[0]};
            wr(4'h6, v);
            check(fastRcCalReference, f[1:0]);
            check(slowRcCalReference, !f[0]);
            rdc(4'h6, v);
        end
        wr(4'h6, 8'h07);
        rdc(4'h6, 8'h05);
        $display("test reference select done");

        wr(4'h2, 8'ha5);
        check(extOscConfig, 8'ha5);
        wr(4'h4, 8'h3c);
        check(slowRcCal, 8'h3c);
        // the 32k reference is switched on before the loop uses it
        wr(4'h0, 8'h05);
        wr(4'h6, 8'h00);
        check(fastRcCalReference, 2'b00);
        check(oscEnable, 5'h05);
        wr(4'ha, 8'h40);
        wr(4'hb, 8'h15);
        check(calValue, {6'h15, 7'h40});
        $display("test manual calibration done");

        wr(4'hd, 8'h00);
        wr(4'he, 8'h01);
        wr(4'h8, 8'h01);
        repeat (1600) @(posedge core_clk);
        rd(4'ha, d);
        check(d > 8'h40, 1'b1);
        check(calValue[12:7], 6'h15);
        wr(4'ha, 8'h00);
        wr(4'hb, 8'h00);
        rd(4'ha, d2);
        check(d2 >= d, 1'b1);
        rdc(4'hb, 8'h15);
        wr(4'he, 8'h00);
        wr(4'hd, 8'h01);
        rd(4'ha, d);
        repeat (1600) @(posedge core_clk);
        rd(4'ha, d2);
        check(d2 < d, 1'b1);
        $display("test calibration loop done");

        // with the reference halted the loop cannot finish stopping
        refOn <= 1'b0;
        wr(4'h8, 8'h00);
        repeat (300) @(posedge core_clk);
        rdc(4'h8, 8'h01);
        refOn <= 1'b1;
        n = 0;
        d = 8'h01;
        while (d !== 8'h00 && n < 400) begin
            rd(4'h8, d);
            n++;
        end
        check(d, 8'h00);
        wr(4'ha, 8'h33);
        check(calValue, {6'h15, 7'h33});
        $display("test loop stop done");

        wr(4'h3, 8'h05);
        rdc(4'h3, 8'h05);
        check(nmiReq, 1'b0);
        @(posedge core_clk) pllLockIn <= 1'b0;
        repeat (6) @(posedge core_clk);
        #1 check(nmiReq, 1'b1);
        rdc(4'h3, 8'h0d);
        @(posedge core_clk) pllLockIn <= 1'b1;
        wr(4'h3, 8'h08);
        repeat (2) @(posedge core_clk);
        #1 check(nmiReq, 1'b0);
        rdc(4'h3, 8'h05);
        @(posedge core_clk) extOscFailIn <= 1'b1;
        repeat (6) @(posedge core_clk);
        #1 check(nmiReq, 1'b1);
        rdc(4'h3, 8'h07);
        wr(4'h3, 8'h02);
        @(posedge core_clk) extOscFailIn <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 check(nmiReq, 1'b0);
        check(nmiVector, 8'h00);
        wr(4'h3, 8'h00);
        rdc(4'h3, 8'h05);
        $display("test failure detection done");
        summarize();
    end
endmodule

`default_nettype wire
